/* verilog/sram_ctl_pkg.sv */
// Purpose: constants and carriers for the latched static RAM controller
// Assumes: 50 MHz clock, all pin timing counted in whole clock cycles
// Notes:   the controller drives the RAM pins; the RAM itself is outside
//
// Notes on behaviour
// - write enable may stay low across writes
// - time write data to enable/select rising edge
// - write pulse may sit anywhere in enable-low window
// - wait float delay before driving write data
package sram_ctl_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;

  // ---------------------------------------------------------------
  // timing, in ns as printed, and derived cycle counts
  // ---------------------------------------------------------------
  localparam int CLK_NS             = 20;
  localparam int ADDR_SETUP_NS      = 20;   // address before enable falls
  localparam int WRITE_PULSE_NS     = 180;  // write enable pulse width
  localparam int DATA_SETUP_NS      = 150;  // data before write end
  localparam int output_float_delay = 50;   // write low to outputs floated
  localparam int ACCESS_NS          = 300;  // enable low to read data valid
  localparam int CYCLE_NS           = 400;  // enable fall to enable fall
  localparam int PRECHARGE_NS       = 120;  // enable high between cycles

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int SETUP_CYC  = cyc_up(ADDR_SETUP_NS);
  localparam int FLOAT_CYC  = cyc_up(output_float_delay);
  localparam int DSETUP_CYC = cyc_up(DATA_SETUP_NS);
  localparam int WPULSE_CYC = cyc_up(WRITE_PULSE_NS);
  localparam int ACCESS_CYC = cyc_up(ACCESS_NS);
  localparam int PRE_CYC    = cyc_up(PRECHARGE_NS);
  localparam int HOLD_CYC   = 1;    // data and write enable kept after write end
  localparam int CNT_W      = 8;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              bank_n;  // value for latched_bank_select_n
  } req_s;

  typedef struct packed {
    logic              enable_n;
    logic              first_select_n;
    logic              latched_bank_select_n;
    logic              write_n;
    logic [ADDR_W-1:0] addr;
  } pins_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_FLOAT, ST_WDATA, ST_READ, ST_END, ST_PRE
  } state_e;

endpackage : sram_ctl_pkg

/* verilog/cycle_timer.sv */
// Purpose: down counter timing each phase of a RAM cycle
// Assumes: load has priority over counting
// Notes:   done is high while the count is zero
module cycle_timer
  import sram_ctl_pkg::*;
#(
  parameter int W = CNT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);

  // refuse a width that cannot count a phase of more than two cycles
  if (W < 2) begin : g_width_check
    $error("cycle_timer width too small");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // count down to zero, reload on request
  assign cnt_nxt = load ? value : (cnt_r != '0 ? cnt_r - W'(1) : cnt_r);
  assign done    = (cnt_r == '0);

  // counter register
  always_ff @(posedge clk) begin
    if (rst) cnt_r <= '0;
    else     cnt_r <= cnt_nxt;
  end

endmodule : cycle_timer

/* verilog/sram_host.sv */
// Purpose: host controller driving a latched-address static RAM
// Assumes: one request at a time, pins sampled on clk
// Notes:   shared data bus split into in, out and output enable
//          one RAM cycle per request; a write ends on the enable and
//          select rise while write enable is still low
module sram_host
  import sram_ctl_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // user request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire req_s              req,
  // user read answer
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  // RAM control pins
  output pins_s                  pins,
  // RAM shared data bus
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_e            st_r, st_nxt;
  req_s              req_r;
  pins_s             pins_r, pins_nxt;
  logic [DATA_W-1:0] dq_out_r, dq_out_nxt;
  logic              dq_oe_r, dq_oe_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic              rd_valid_r;
  logic              tload;
  logic [CNT_W-1:0]  tval;
  logic              tdone;
  logic              take;
  logic              cap_read;
  logic              setup_end;
  logic              float_end;
  logic              wdata_end;
  logic              read_end;
  logic              hold_end;
  logic              pre_end;

  // ---------------------------------------------------------------
  // phase lengths
  // ---------------------------------------------------------------
  // the data phase covers the data setup before the write ends and
  // whatever the write pulse still needs after the bus turn-round
  localparam int WDATA_CYC = (DSETUP_CYC > WPULSE_CYC - FLOAT_CYC) ? DSETUP_CYC : WPULSE_CYC - FLOAT_CYC;
  localparam int CNT_MAX   = (1 << CNT_W) - 1;

  // refuse setup, access, data and precharge lengths that the timer cannot hold
  if (SETUP_CYC > CNT_MAX || ACCESS_CYC > CNT_MAX || WDATA_CYC > CNT_MAX || PRE_CYC > CNT_MAX) begin : g_cnt_range
    $error("sram_host phase count too large for the timer");
  end

  // a missing float or hold phase would let host and RAM fight on the bus
  if (FLOAT_CYC < 1 || HOLD_CYC < 1) begin : g_turn_round
    $error("sram_host bus turn-round phase shorter than one cycle");
  end

  // timer load value c for a phase of c+1 cycles, range checked above for all but the float and hold phases
  function automatic logic [CNT_W-1:0] phase_len(input int c);
    return CNT_W'(c);
  endfunction : phase_len

  // phase timer
  cycle_timer #(.W(CNT_W)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tload),
    .value (tval),
    .done  (tdone)
  );

  // handshake decode
  assign req_ready = (st_r == ST_IDLE);
  assign take      = req_valid && req_ready;
  assign cap_read  = read_end;

  // phase-end decode, one strobe per timed phase
  assign setup_end = (st_r == ST_SETUP) && tdone;
  assign float_end = (st_r == ST_FLOAT) && tdone;
  assign wdata_end = (st_r == ST_WDATA) && tdone;
  assign read_end  = (st_r == ST_READ)  && tdone;
  assign hold_end  = (st_r == ST_END)   && tdone;
  assign pre_end   = (st_r == ST_PRE)   && tdone;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // write: setup, enable/select/write low, float wait, data phase,
  //        enable and select rise (write ends), hold, write enable rise
  // read:  setup, enable/select low for the access time, capture
  // both end in a precharge with enable high before the next request
  always_comb begin
    st_nxt     = st_r;
    pins_nxt   = pins_r;
    dq_out_nxt = dq_out_r;
    dq_oe_nxt  = dq_oe_r;
    tload      = 1'b0;
    tval       = '0;
    case (st_r)
      ST_IDLE: begin
        if (take) begin
          // address and bank select set up while enable high
          pins_nxt.addr                  = req.addr;
          pins_nxt.latched_bank_select_n = req.bank_n;
          tload  = 1'b1;
          tval   = phase_len(SETUP_CYC);
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (setup_end) begin
          // enable falls: device latches address and bank select
          pins_nxt.enable_n       = 1'b0;
          pins_nxt.first_select_n = 1'b0;
          tload = 1'b1;
          if (req_r.write) begin
            pins_nxt.write_n = 1'b0;      // pulse opens inside enable-low window
            tval   = phase_len(FLOAT_CYC);
            st_nxt = ST_FLOAT;
          end else begin
            // read: enable stays low for the full access time
            tval   = phase_len(ACCESS_CYC);
            st_nxt = ST_READ;
          end
        end
      end
      ST_FLOAT: begin
        // outputs floated by write low before bus is driven
        if (float_end) begin
          dq_out_nxt = req_r.wdata;
          dq_oe_nxt  = 1'b1;              // host drives shared bus
          tload  = 1'b1;
          tval   = phase_len(WDATA_CYC);
          st_nxt = ST_WDATA;
        end
      end
      ST_WDATA: begin
        // data held stable to first rise of enable/select
        if (wdata_end) begin
          pins_nxt.enable_n       = 1'b1; // ends write
          pins_nxt.first_select_n = 1'b1;
          tload  = 1'b1;
          tval   = phase_len(HOLD_CYC);
          st_nxt = ST_END;
        end
      end
      ST_READ: begin
        // access time over: enable rises and the RAM latches its output
        if (read_end) begin
          pins_nxt.enable_n       = 1'b1; // device holds its output
          pins_nxt.first_select_n = 1'b1;
          tload  = 1'b1;
          tval   = phase_len(PRE_CYC);
          st_nxt = ST_PRE;
        end
      end
      ST_END: begin
        // write enable released after data hold, bus turned round
        if (hold_end) begin
          pins_nxt.write_n = 1'b1;        // one write per cycle
          dq_oe_nxt = 1'b0;
          tload  = 1'b1;
          tval   = phase_len(PRE_CYC);
          st_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        // enable kept high long enough for the RAM to precharge
        if (pre_end) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // request and pin registers
  // the request is kept for the whole cycle, the user may change req once taken
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r     <= ST_IDLE;
      req_r    <= '0;
      pins_r   <= '{enable_n: 1'b1, first_select_n: 1'b1, latched_bank_select_n: 1'b1,
                    write_n: 1'b1, addr: '0};
      dq_out_r <= '0;
      dq_oe_r  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      if (take) req_r <= req;
      pins_r   <= pins_nxt;
      dq_out_r <= dq_out_nxt;
      dq_oe_r  <= dq_oe_nxt;
    end
  end

  // read capture at end of access time
  // dq_in is taken at the edge that raises enable, so the RAM still
  // drives the word it had valid when its output latch closed
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= cap_read;
      if (cap_read) rd_data_r <= dq_in;
    end
  end

  // outputs
  assign pins     = pins_r;
  assign dq_out   = dq_out_r;
  assign dq_oe    = dq_oe_r;
  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;

endmodule : sram_host

/* testbench/sram_dev_model.sv */
// Purpose: behavioural latched static RAM on the far side of the host
// Assumes: pins come from the host, the bench resolves the shared bus
// Notes:   slow delays the read answer to near the access limit
module sram_dev_model
  import sram_ctl_pkg::*;
(
  // host pins
  input  wire pins_s             pins,
  input  wire logic [DATA_W-1:0] bus,
  input  wire logic              slow,
  // read side
  output logic [DATA_W-1:0]      q,
  output logic                   oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] d, q_r, q_slow;
  logic [ADDR_W-1:0] a;
  logic              bank, act;
  wire               wr = !pins.enable_n && !pins.first_select_n && !pins.write_n && !bank;
  // empty array, no write open
  initial begin
    foreach (mem[i]) mem[i] = '0;
    a = '0;
    bank = 1'b1;
    act = 1'b0;
  end
  // enable falling edge latches address and bank select
  always @(negedge pins.enable_n) begin
    a = pins.addr;
    bank = pins.latched_bank_select_n;
  end
  // last bus value seen while writing is stored when the write ends
  always @(wr, bus) begin
    if (wr) begin
      act = 1'b1;
      d = bus;
    end else if (act) begin
      // a bank select latched high closes the window without storing
      if (!bank) mem[a] = d;
      act = 1'b0;
    end
  end
  // output latch follows the array while enable is low
  always @* if (!pins.enable_n) q_r = mem[a];
  assign #280 q_slow = q_r;
  assign q  = slow ? q_slow : q_r;
  // outputs float whenever write enable is low
  assign oe = !pins.first_select_n && pins.write_n && !bank;
endmodule : sram_dev_model

/* testbench/sram_host_chk.sv */
// Purpose: pin timing checks on the RAM host
// Assumes: counts as in the package
// Notes:   bound onto sram_host
module sram_host_chk
  import sram_ctl_pkg::*;
(
  // clock, reset, user side
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire req_s              req,
  input wire logic              rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  // RAM side
  input wire pins_s             pins,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  idle_pins_a: assert property (req_ready |-> pins.enable_n && pins.first_select_n && !dq_oe)
    else $error("pins active while idle");
  float_wait_a: assert property ($fell(pins.write_n) |-> !dq_oe [*3])
    else $error("data driven before float delay");
  bus_dir_a: assert property (dq_oe |-> !pins.write_n)
    else $error("bus driven with write high");
  latch_hold_a: assert property (!pins.enable_n |-> $stable({pins.addr, pins.latched_bank_select_n}))
    else $error("address moved while enabled");
  pulse_inside_a: assert property ($fell(pins.write_n) |-> !pins.enable_n && !pins.first_select_n)
    else $error("write pulse outside window");
  pulse_len_a: assert property ($fell(pins.write_n) |-> !pins.write_n [*8])
    else $error("write pulse too short");
  data_held_a: assert property ($rose(pins.enable_n) && !pins.write_n |-> dq_oe && $stable(dq_out))
    else $error("data not held to write end");
  write_end_a: assert property ($rose(pins.enable_n) && !pins.write_n |-> ##2 pins.write_n && !dq_oe)
    else $error("write not closed");
  read_time_a: assert property (req_valid && req_ready && !req.write |-> ##19 rd_valid)
    else $error("read answer late");
  cover property ($rose(rd_valid));
  cover property ($fell(pins.write_n));
  cover property ($fell(pins.enable_n) && pins.latched_bank_select_n);
endmodule : sram_host_chk

bind sram_host sram_host_chk i_sram_host_chk (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the RAM host
// Assumes: one request at a time, random mix from a fixed seed
// Notes:   reads compare against a shadow of stored words
module tb_top
  import sram_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst, req_valid, req_ready, rd_valid, dq_oe, m_oe, slow;
  req_s              req;
  pins_s             pins;
  logic [DATA_W-1:0] rd_data, dq_in, dq_out, m_q, cyc;
  logic [DATA_W-1:0] shadow [256];
  logic [31:0]       rnd;
  int                n_mismatch, checked;
  sram_host i_sram_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  sram_dev_model i_sram_dev_model (.pins(pins), .bus(dq_in), .slow(slow), .q(m_q), .oe(m_oe));
  // released bus shows a pattern that moves every cycle
  assign dq_in = dq_oe ? dq_out : (m_oe ? m_q : cyc);
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 4'h1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // a write lands only when its bank select is latched low
  function automatic logic stores(input logic w, input logic b);
    return w && !b;
  endfunction : stores
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // one request, then the read answer when it is a read
  task automatic op(input logic w, input logic [7:0] a, input logic [3:0] d, input logic b);
    @(posedge clk);
    req <= '{write: w, addr: a, wdata: d, bank_n: b};
    req_valid <= 1'b1;
    slow <= rnd[20];
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    if (stores(w, b)) shadow[a] = d;
    if (!w) begin
      do @(posedge clk); while (rd_valid !== 1'b1);
      check(rd_data, shadow[a]);
    end
  endtask : op
  // corner cases first, then a random mix over a few addresses
  initial begin
    clk = 0;
    rst = 1;
    req_valid = 0;
    req = '0;
    slow = 0;
    cyc = '0;
    rnd = 32'h0cac989a;
    foreach (shadow[i]) shadow[i] = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    op(1'b1, 8'hff, 4'ha, 1'b0);
    op(1'b1, 8'h00, 4'h5, 1'b0);
    op(1'b1, 8'hff, 4'h3, 1'b1);
    op(1'b0, 8'hff, 4'h0, 1'b0);
    op(1'b0, 8'h00, 4'h0, 1'b0);
    repeat (60) begin
      rnd = xs(rnd);
      op(rnd[0], {4'h0, rnd[7:4]}, rnd[11:8], rnd[0] & rnd[12] & rnd[13]);
    end
    report_and_stop();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
